// ==== tb_tbc_ctrl.sv ====
// self-checking bench for the capture buffer control register
module tb_tbc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] wd; logic [31:0] exp;} tbc_row_t;
    tbc_row_t rows [6] = '{
        '{32'h8002_1000, 32'h0002_1000}, '{32'h0010_0000, 32'h0002_1000},
        '{32'h8000_0000, 32'h0000_0000}, '{32'h8010_3000, 32'h0010_3000},
        '{32'h8004_0000, 32'h0004_0000}, '{32'h8010_0000, 32'h0010_0000}};
    logic ref_clk = 1'b0;
    logic rst, sw_req, sw_we, cap_en, trace_valid;
    logic [4:0] sw_sel;
    logic [31:0] sw_wdata, trace_word;
    logic ctrl_we, dp_req, filt, prb, full;
    logic [4:0] dp_sel;
    logic [31:0] ctrl_wdata, ctrl_rdata, dp_wdata, dp_rdata, sw_rdata, rd;
    int n_fail = 0;
    int n_tests = 0;
    always #2 ref_clk = ~ref_clk;
    tbc_probe probe (.clk(ref_clk), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .dp_req(dp_req),
        .dp_sel(dp_sel), .dp_wdata(dp_wdata), .dp_rdata(dp_rdata));
    tbc_ctrl #(.DEPTH(8)) dut (.REF_CLK(ref_clk), .RST(rst), .CTRL_WE(ctrl_we),
        .CTRL_WDATA(ctrl_wdata), .CTRL_RDATA(ctrl_rdata), .DP_REQ(dp_req), .DP_SEL(dp_sel),
        .DP_WDATA(dp_wdata), .DP_RDATA(dp_rdata), .SW_REQ(sw_req), .SW_WE(sw_we),
        .SW_SEL(sw_sel), .SW_WDATA(sw_wdata), .SW_RDATA(sw_rdata), .CAPTURE_EN(cap_en),
        .TRACE_VALID(trace_valid), .TRACE_WORD(trace_word), .FILTERED_MODE(filt),
        .PROBE_ONLY(prb), .BUFFER_FULL(full));
    ////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sw(input logic we, input logic [4:0] sel, input logic [31:0] wd);
        @(negedge ref_clk);
        sw_req = 1'b1;
        sw_we = we;
        sw_sel = sel;
        sw_wdata = wd;
        @(negedge ref_clk);
        sw_req = 1'b0;
        sw_wdata = ~wd;
    endtask
    task automatic cap(input int n);
        repeat (n) begin
            @(negedge ref_clk);
            trace_valid = 1'b1;
            @(negedge ref_clk);
            trace_valid = 1'b0;
            trace_word = trace_word + 32'h1;
        end
    endtask
    // bounded, so a readout that never ends cannot hang the run
    task automatic wait_clear();
        for (int i = 0; i < 20; i++) begin
            @(negedge ref_clk);
            if (ctrl_rdata[16] === 1'b0) return;
        end
        n_fail++;
        final_report();
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        sw_req = 1'b0;
        sw_we = 1'b0;
        cap_en = 1'b0;
        trace_valid = 1'b0;
        sw_sel = 5'h00;
        sw_wdata = 32'h0;
        trace_word = 32'h0;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        check(ctrl_rdata, 32'h0);
        check({29'h0, filt, prb, full}, 32'h0);
        foreach (rows[i]) begin
            probe.wr(rows[i].wd);
            check(ctrl_rdata, rows[i].exp);
            check({30'h0, prb, filt}, {30'h0, rows[i].exp[18:17]});
        end
        $display("table done");
        probe.wr(32'h8014_0000);
        sw(1'b1, 5'h03, 32'h7);
        sw(1'b0, 5'h00, 32'h0);
        check(sw_rdata, 32'h0);
        probe.access(5'h03, 32'h0, rd);
        check(rd, 32'h0);
        probe.wr(32'h8010_0000);
        sw(1'b1, 5'h03, 32'h7);
        probe.access(5'h03, 32'h7, rd);
        check(rd, 32'h7);
        probe.wr(32'h8011_8000);
        check(ctrl_rdata, 32'h0010_0000);
        for (int s = 1; s < 4; s++) begin
            probe.access(5'(s), 32'h0, rd);
            check(rd, 32'h0);
        end
        $display("access done");
        cap_en = 1'b1;
        cap(7);
        check({31'h0, full}, 32'h0);
        cap(1);
        check({31'h0, full}, 32'h1);
        probe.wr(32'h8010_8000);
        check({31'h0, full}, 32'h0);
        probe.wr(32'h8010_1000);
        cap(10);
        probe.access(5'h02, 32'h0, rd);
        check(rd, 32'h0);
        check(ctrl_rdata, 32'h0010_5000);
        probe.wr(32'h8010_9000);
        trace_word = 32'ha0;
        cap(3);
        cap_en = 1'b0;
        cap(1);
        probe.access(5'h02, 32'h3, rd);
        check(rd, 32'h3);
        probe.wr(32'h8011_1000);
        check({31'h0, ctrl_rdata[16]}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            probe.access(5'h00, 32'h0, rd);
            check(rd, 32'ha0 + i);
        end
        wait_clear();
        $display("fill and readout done");
        // software load of the trace word walks the read pointer too
        probe.wr(32'h8011_1000);
        sw(1'b0, 5'h00, 32'h0);
        check(sw_rdata, 32'ha0);
        probe.access(5'h01, 32'h1, rd);
        check(rd, 32'h1);
        // pointer reset in mid readout drops readout, then permit off refuses probe pointer writes
        probe.wr(32'h8000_8000);
        check(ctrl_rdata, 32'h0);
        probe.access(5'h03, 32'h5, rd);
        probe.access(5'h03, 32'h0, rd);
        check(rd, 32'h0);
        $display("readout and permit done");
        rst = 1'b1;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        check(ctrl_rdata, 32'h0);
        $display("reset done");
        final_report();
    end
endmodule

// ==== tbc_ctrl.sv ====
// control register and access paths of the capture buffer unit
`include "tbc_defs.svh"
module tbc_ctrl
    import tbc_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int DW = 32,
    parameter bit PROBE_ACCESS = 1'b1
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CTRL_WE,
    input wire logic [31:0] CTRL_WDATA,
    output logic [31:0] CTRL_RDATA,
    input wire logic DP_REQ,
    input wire logic [`TBC_SEL_W-1:0] DP_SEL,
    input wire logic [31:0] DP_WDATA,
    output logic [31:0] DP_RDATA,
    input wire logic SW_REQ,
    input wire logic SW_WE,
    input wire logic [`TBC_SEL_W-1:0] SW_SEL,
    input wire logic [31:0] SW_WDATA,
    output logic [31:0] SW_RDATA,
    input wire logic CAPTURE_EN,
    input wire logic TRACE_VALID,
    input wire logic [DW-1:0] TRACE_WORD,
    output logic FILTERED_MODE,
    output logic PROBE_ONLY,
    output logic BUFFER_FULL
);
    localparam int AW = $clog2(DEPTH);

    tbc_ctrl_t s;
    tbc_ctrl_t next_s;

    tbc_if #(.AW(AW), .DW(DW)) bus ();

    tbc_ptr #(.DEPTH(DEPTH), .DW(DW)) u_ptr (
        .clk(REF_CLK),
        .rst(RST),
        .cap_en(CAPTURE_EN),
        .trace_valid(TRACE_VALID),
        .trace_word(TRACE_WORD),
        .bus(bus.ptr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] reg_read(
        input logic [`TBC_SEL_W-1:0] sel,
        input logic [DW-1:0] word,
        input logic [AW-1:0] rdp,
        input logic [AW-1:0] wp,
        input logic [AW-1:0] stp
    );
        logic [31:0] r;
        r = 32'h0;
        case (sel)
            `TBC_SEL_TRACE_WORD: r = 32'(word);
            `TBC_SEL_READ_PTR: r = 32'(rdp);
            `TBC_SEL_WRITE_PTR: r = 32'(wp);
            `TBC_SEL_START_PTR: r = 32'(stp);
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    function automatic logic is_ptr(input logic [`TBC_SEL_W-1:0] sel);
        return sel == `TBC_SEL_READ_PTR || sel == `TBC_SEL_WRITE_PTR
            || sel == `TBC_SEL_START_PTR;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic dp_wr;
    logic sw_wr;
    logic [`TBC_SEL_W-1:0] wr_sel;
    logic [31:0] wr_val;
    logic [31:0] image;

    always_comb begin
        next_s = s;
        bus.ptr_reset = 1'b0;
        bus.load_rdp = 1'b0;
        bus.rd_adv = 1'b0;
        bus.fill_mode = s.fill_mode;
        image = 32'h0;
        image[`TBC_STORE_PERMIT_BIT] = s.store_permit;
        image[`TBC_RSVD_BIT] = 1'b0;
        image[`TBC_PROBE_ONLY_BIT] = s.probe_only;
        image[`TBC_FILTERED_BIT] = s.filtered;
        image[`TBC_READOUT_BIT] = s.readout;
        image[`TBC_PTR_RESET_BIT] = s.ptr_reset;
        image[`TBC_FULL_BIT] = bus.full;
        image[`TBC_FILL_MSB:`TBC_FILL_LSB] = s.fill_mode;
        image[`TBC_GATE_BIT] = 1'b0;
        next_s.ctrl_rdata = image;

        // requested reset runs this cycle, then the bit drops
        if (s.ptr_reset) begin
            bus.ptr_reset = 1'b1;
            next_s.ptr_reset = 1'b0;
        end

        // readout ends once the read pointer meets the write pointer
        if (s.state == TBC_READ && bus.rdp == bus.wp) begin
            next_s.readout = 1'b0;
            next_s.state = TBC_IDLE;
        end

        // probe access: the read always happens, the write only with permission
        dp_wr = DP_REQ && s.store_permit && is_ptr(DP_SEL);
        if (DP_REQ) begin
            next_s.dp_rdata = reg_read(DP_SEL, bus.rd_word, bus.rdp, bus.wp, bus.stp);
            if (DP_SEL == `TBC_SEL_TRACE_WORD && s.readout) begin
                bus.rd_adv = 1'b1;
            end
        end

        // while probe only is set, software writes are refused and trace word reads give zero; pointer reads still pass
        sw_wr = 1'b0;
        if (SW_REQ) begin
            if (s.probe_only) begin
                next_s.sw_rdata = (SW_SEL == `TBC_SEL_TRACE_WORD) ? 32'h0
                    : reg_read(SW_SEL, bus.rd_word, bus.rdp, bus.wp, bus.stp);
            end else begin
                next_s.sw_rdata = reg_read(SW_SEL, bus.rd_word, bus.rdp, bus.wp, bus.stp);
                sw_wr = SW_WE && is_ptr(SW_SEL);
                if (!SW_WE && SW_SEL == `TBC_SEL_TRACE_WORD && s.readout) begin
                    bus.rd_adv = 1'b1;
                end
            end
        end

        // probe write wins when both paths hit a pointer in one cycle
        wr_sel = dp_wr ? DP_SEL : SW_SEL;
        wr_val = dp_wr ? DP_WDATA : SW_WDATA;
        bus.wdata = wr_val[AW-1:0];
        bus.wr_rdp = (dp_wr || sw_wr) && wr_sel == `TBC_SEL_READ_PTR;
        bus.wr_wp = (dp_wr || sw_wr) && wr_sel == `TBC_SEL_WRITE_PTR;
        bus.wr_stp = (dp_wr || sw_wr) && wr_sel == `TBC_SEL_START_PTR;

        if (CTRL_WE && CTRL_WDATA[`TBC_GATE_BIT]) begin
            next_s.store_permit = CTRL_WDATA[`TBC_STORE_PERMIT_BIT];
            next_s.probe_only = PROBE_ACCESS && CTRL_WDATA[`TBC_PROBE_ONLY_BIT];
            next_s.filtered = CTRL_WDATA[`TBC_FILTERED_BIT];
            next_s.fill_mode = CTRL_WDATA[`TBC_FILL_MSB:`TBC_FILL_LSB];
            if (CTRL_WDATA[`TBC_PTR_RESET_BIT]) begin
                next_s.ptr_reset = 1'b1;
                next_s.readout = 1'b0;
                next_s.state = TBC_IDLE;
            end else if (CTRL_WDATA[`TBC_READOUT_BIT]) begin
                next_s.readout = 1'b1;
                next_s.state = TBC_READ;
                bus.load_rdp = 1'b1;
            end
        end

        case (next_s.state)
            TBC_IDLE: next_s.state = TBC_IDLE;
            TBC_READ: next_s.state = TBC_READ;
            default: next_s.state = TBC_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s <= '{store_permit: `TBC_RST_STORE_PERMIT, probe_only: `TBC_RST_PROBE_ONLY,
                   filtered: `TBC_RST_FILTERED, readout: `TBC_RST_READOUT,
                   ptr_reset: `TBC_RST_PTR_RESET, fill_mode: `TBC_RST_FILL,
                   state: TBC_IDLE, ctrl_rdata: 32'h0, dp_rdata: 32'h0, sw_rdata: 32'h0};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign CTRL_RDATA = s.ctrl_rdata;
    assign DP_RDATA = s.dp_rdata;
    assign SW_RDATA = s.sw_rdata;
    assign FILTERED_MODE = s.filtered;
    assign PROBE_ONLY = s.probe_only;
    assign BUFFER_FULL = bus.full;
endmodule

// ==== tbc_ctrl_props.sv ====
// assertions on the capture buffer control register ports
module tbc_ctrl_props
    import tbc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CTRL_WE,
    input wire logic [31:0] CTRL_WDATA,
    input wire logic [31:0] CTRL_RDATA,
    input wire logic SW_REQ,
    input wire logic SW_WE,
    input wire logic [4:0] SW_SEL,
    input wire logic [31:0] SW_RDATA,
    input wire logic FILTERED_MODE,
    input wire logic PROBE_ONLY,
    input wire logic BUFFER_FULL
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    wire logic gated = CTRL_WE && CTRL_WDATA[31];
    wire logic ptr_rst = gated && CTRL_WDATA[15];
    ////////////////////////////////////////////////////////////////
    property p_gate; CTRL_RDATA[31] == 1'b0; endproperty
    a_gate: assert property (p_gate) else $error("gate bit reads one");
    property p_rsvd; CTRL_RDATA[19] == 1'b0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
    property p_img; gated |-> ##2 {CTRL_RDATA[20], CTRL_RDATA[18:17], CTRL_RDATA[13:12]}
        == $past({CTRL_WDATA[20], CTRL_WDATA[18:17], CTRL_WDATA[13:12]}, 2); endproperty
    a_img: assert property (p_img) else $error("register image wrong");
    property p_filt; gated |=> FILTERED_MODE == $past(CTRL_WDATA[17]); endproperty
    a_filt: assert property (p_filt) else $error("filtered mode wrong");
    property p_hold; !gated |=> $stable({FILTERED_MODE, PROBE_ONLY}); endproperty
    a_hold: assert property (p_hold) else $error("mode bits moved");
    property p_self; CTRL_RDATA[15] |=> !CTRL_RDATA[15]; endproperty
    a_self: assert property (p_self) else $error("pointer reset stuck");
    property p_clr; ptr_rst |-> ##3 CTRL_RDATA[16:14] == 3'h0 && !BUFFER_FULL; endproperty
    a_clr: assert property (p_clr) else $error("pointer reset left bits");
    property p_full; $fell(BUFFER_FULL) |-> $past(ptr_rst, 2); endproperty
    a_full: assert property (p_full) else $error("full flag lost");
    property p_prb; PROBE_ONLY && SW_REQ && !SW_WE && SW_SEL == 5'h00
        |=> SW_RDATA == 32'h0; endproperty
    a_prb: assert property (p_prb) else $error("software read not zero");
endmodule
bind tbc_ctrl tbc_ctrl_props u_props (
    .REF_CLK(REF_CLK), .RST(RST), .CTRL_WE(CTRL_WE), .CTRL_WDATA(CTRL_WDATA),
    .CTRL_RDATA(CTRL_RDATA), .SW_REQ(SW_REQ), .SW_WE(SW_WE), .SW_SEL(SW_SEL),
    .SW_RDATA(SW_RDATA), .FILTERED_MODE(FILTERED_MODE), .PROBE_ONLY(PROBE_ONLY),
    .BUFFER_FULL(BUFFER_FULL));

// ==== tbc_defs.svh ====
// bit positions, reset values, fill modes and selector codes of the capture buffer unit
`ifndef TBC_DEFS_SVH
`define TBC_DEFS_SVH

`define TBC_GATE_BIT 31
`define TBC_STORE_PERMIT_BIT 20
`define TBC_RSVD_BIT 19
`define TBC_PROBE_ONLY_BIT 18
`define TBC_FILTERED_BIT 17
`define TBC_READOUT_BIT 16
`define TBC_PTR_RESET_BIT 15
`define TBC_FULL_BIT 14
`define TBC_FILL_MSB 13
`define TBC_FILL_LSB 12

`define TBC_RST_STORE_PERMIT 1'h0
`define TBC_RST_PROBE_ONLY 1'h0
`define TBC_RST_FILTERED 1'h0
`define TBC_RST_READOUT 1'h0
`define TBC_RST_PTR_RESET 1'h0
`define TBC_RST_FULL 1'h0
`define TBC_RST_FILL 2'h0

`define TBC_FILL_WRAP 2'h0
`define TBC_FILL_STOP 2'h1

`define TBC_SEL_W 5
`define TBC_SEL_TRACE_WORD 5'h00
`define TBC_SEL_READ_PTR 5'h01
`define TBC_SEL_WRITE_PTR 5'h02
`define TBC_SEL_START_PTR 5'h03

`endif

// ==== tbc_if.sv ====
// link between control logic and trace memory pointers
interface tbc_if #(
    parameter int AW = 8,
    parameter int DW = 32
);
    logic ptr_reset;
    logic load_rdp;
    logic rd_adv;
    logic wr_rdp;
    logic wr_wp;
    logic wr_stp;
    logic [AW-1:0] wdata;
    logic [1:0] fill_mode;
    logic [AW-1:0] rdp;
    logic [AW-1:0] wp;
    logic [AW-1:0] stp;
    logic full;
    logic [DW-1:0] rd_word;

    modport ctrl (
        output ptr_reset, load_rdp, rd_adv, wr_rdp, wr_wp, wr_stp, wdata, fill_mode,
        input rdp, wp, stp, full, rd_word
    );
    modport ptr (
        input ptr_reset, load_rdp, rd_adv, wr_rdp, wr_wp, wr_stp, wdata, fill_mode,
        output rdp, wp, stp, full, rd_word
    );
endinterface

// ==== tbc_pkg.sv ====
// types shared by the capture buffer unit
package tbc_pkg;

    typedef enum logic [1:0] {
        TBC_IDLE = 2'b01,
        TBC_READ = 2'b10
    } tbc_state_t;

    typedef struct packed {
        logic store_permit;
        logic probe_only;
        logic filtered;
        logic readout;
        logic ptr_reset;
        logic [1:0] fill_mode;
        tbc_state_t state;
        logic [31:0] ctrl_rdata;
        logic [31:0] dp_rdata;
        logic [31:0] sw_rdata;
    } tbc_ctrl_t;

endpackage

// ==== tbc_probe.sv ====
// debug probe model: control writes and data port accesses
module tbc_probe (
    input wire logic clk,
    output logic ctrl_we,
    output logic [31:0] ctrl_wdata,
    output logic dp_req,
    output logic [4:0] dp_sel,
    output logic [31:0] dp_wdata,
    input wire logic [31:0] dp_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ctrl_we = 1'b0;
        ctrl_wdata = 32'h0;
        dp_req = 1'b0;
        dp_sel = 5'h00;
        dp_wdata = 32'h0;
    end
    // spaced out so the image has settled when the task returns
    task automatic wr(input logic [31:0] d);
        @(negedge clk);
        ctrl_we = 1'b1;
        ctrl_wdata = d;
        @(negedge clk);
        ctrl_we = 1'b0;
        ctrl_wdata = ~d;
        repeat (2) @(negedge clk);
    endtask
    task automatic access(input logic [4:0] sel, input logic [31:0] wd, output logic [31:0] rd);
        @(negedge clk);
        dp_req = 1'b1;
        dp_sel = sel;
        dp_wdata = wd;
        @(negedge clk);
        dp_req = 1'b0;
        dp_sel = ~sel;
        dp_wdata = ~wd;
        rd = dp_rdata;
    endtask
endmodule

// ==== tbc_ptr.sv ====
// trace memory with start, read and write pointers and full flag
`include "tbc_defs.svh"
module tbc_ptr
    import tbc_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int DW = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cap_en,
    input wire logic trace_valid,
    input wire logic [DW-1:0] trace_word,
    tbc_if.ptr bus
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] rdp;
        logic [AW-1:0] wp;
        logic [AW-1:0] stp;
        logic full;
    } tbc_ptr_t;

    tbc_ptr_t s;
    tbc_ptr_t next_s;
    logic cap;
    logic [DW-1:0] mem [DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        cap = 1'b0;
        if (bus.ptr_reset) begin
            next_s = '0;
        end else begin
            if (bus.load_rdp) begin
                next_s.rdp = s.stp;
            end else if (bus.rd_adv) begin
                next_s.rdp = s.rdp + 1'b1;
            end
            if (bus.wr_rdp) begin
                next_s.rdp = bus.wdata;
            end
            if (bus.wr_stp) begin
                next_s.stp = bus.wdata;
            end
            // fill stops as soon as capture enable drops, reserved codes never fill
            if (cap_en && trace_valid) begin
                if (bus.fill_mode == `TBC_FILL_WRAP) begin
                    cap = 1'b1;
                end else if (bus.fill_mode == `TBC_FILL_STOP && !s.full) begin
                    cap = 1'b1;
                end
            end
            if (cap) begin
                next_s.wp = s.wp + 1'b1;
                if (s.full) begin
                    next_s.stp = s.stp + 1'b1;
                end else if (s.wp + 1'b1 == s.stp) begin
                    next_s.full = 1'b1;
                end
            end else if (bus.wr_wp) begin
                next_s.wp = bus.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (cap) begin
            mem[s.wp] <= trace_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign bus.rdp = s.rdp;
    assign bus.wp = s.wp;
    assign bus.stp = s.stp;
    assign bus.full = s.full;
    assign bus.rd_word = mem[s.rdp];
endmodule
